/* hdl/switch_global_control.sv */
// Global control bits of the switch: two 8-bit registers, table flush walker,
// control-frame filter, flow-control gating, aging timer and strap capture.
// Assumes register port, tables, link and frame inputs share clk; straps are pins.
// Behaviour
// RULE_01: Dynamic flush bit starts flush, self-clears.
// RULE_02: Dynamic flush removes entries of learning-disabled ports.
// RULE_03: Static flush bit flushes matching entries, self-clears.
// RULE_04: Match: unicast, single port, learning disabled.
// RULE_05: Bits 3 and 2 read one, unchangeable.
// RULE_06: Compliance mode drops 0x8808 or pause address.
// RULE_07: Otherwise drop only classified flow control frames.
// RULE_08: Link loss gives one fast age cycle.
// RULE_09: Any port link loss ages out everything.
// RULE_10: Pass-all forwards every frame including bad. The code still drops control frames under pass-all.
// RULE_11: 2K frame acceptance bit, resets zero.
// RULE_12: Tx flow control follows negotiation unless disabled.
// RULE_13: Rx flow control follows negotiation unless disabled.
// RULE_14: One strap sets both flow-control disable resets.
// RULE_15: Length check drops mismatched short length fields.
// RULE_16: Aging enable bit, resets one.
// RULE_17: Fast age bit selects 800 us period.
// RULE_18: Aggressive back-off bit, reset from strap.
// RULE_19: Flush bit reads one until flush ends.
`timescale 1ns/1ps
`default_nettype none

module switch_global_control #(
  parameter logic [switch_global_pkg::AGE_CNT_W-1:0] FAST_AGE_CYCLES =
    switch_global_pkg::FAST_AGE_CYCLES,
  parameter logic [switch_global_pkg::AGE_CNT_W-1:0] NORMAL_AGE_CYCLES =
    switch_global_pkg::NORMAL_AGE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  // Management register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Strap pins
  input wire logic flow_ctrl_strap_pin,
  input wire logic backoff_strap_pin,
  // Per-port state
  input wire logic [switch_global_pkg::NUM_PORTS-1:0] learnDisable,
  input wire logic [switch_global_pkg::NUM_PORTS-1:0] linkUp,
  // Dynamic table walk
  output logic [switch_global_pkg::DYN_ADDR_W-1:0] dynAddr,
  input wire switch_global_pkg::dyn_entry_t dynEntry,
  output logic dynInvalidate,
  // Static table walk
  output logic [switch_global_pkg::STAT_ADDR_W-1:0] statAddr,
  input wire switch_global_pkg::stat_entry_t statEntry,
  output logic statInvalidate,
  // Frame filter
  input wire logic frameValid,
  input wire switch_global_pkg::frame_info_t frameInfo,
  output logic dropValid,
  output logic dropFrame,
  // Flow control
  input wire logic anTxPause,
  input wire logic anRxPause,
  output logic txFlowEn,
  output logic rxFlowEn,
  // Aging and mode outputs
  output logic ageTick,
  output logic ageAll,
  output logic aggressiveBackoff,
  output logic hugeFrameEn
);

  // Stored register bits
  // Bits 3 and 2 of control zero are not stored; they are constants in the read image
  logic compliance_drop_mode;
  logic linkChangeAge;
  logic [7:0] ctrlOne;
  logic flushDynBusy;
  logic flushStatBusy;

  // Strap synchronisers and capture
  // Both strap pins are asynchronous to clk, hence the two-flop chains
  logic [1:0] strapMeta;
  logic [1:0] strapSync;
  logic [1:0] strapWait;
  logic strapDone;

  // Flush walker
  switch_global_pkg::flush_state_t flushState;
  switch_global_pkg::flush_state_t next_flushState;
  logic [switch_global_pkg::DYN_ADDR_W-1:0] dynIdx;
  logic [switch_global_pkg::STAT_ADDR_W-1:0] statIdx;

  // Aging
  logic [switch_global_pkg::AGE_CNT_W-1:0] ageCnt;
  logic fastPending;
  logic [switch_global_pkg::NUM_PORTS-1:0] linkPrev;

  // True when a forwarding set names exactly one port
  function automatic logic single_port(input logic [switch_global_pkg::NUM_PORTS-1:0] ports);
    single_port = (ports != '0) && ((ports & (ports - 1'b1)) == '0);
  endfunction

  // Address decode
  // Unmapped addresses match neither select: writes there vanish, reads give zero
  wire selZero = regAddr == switch_global_pkg::ADDR_GLOBAL_CTRL_ZERO;
  wire selOne = regAddr == switch_global_pkg::ADDR_GLOBAL_CTRL_ONE;
  wire wrZero = regWrite && selZero;
  wire wrOne = regWrite && selOne;
  wire reqDyn = wrZero && regWrData[switch_global_pkg::CZ_FLUSH_DYN];
  wire reqStat = wrZero && regWrData[switch_global_pkg::CZ_FLUSH_STAT];

  // Read image; reserved bits fixed at one, upper bits of register zero read zero
  // Busy flags stand in for the trigger bits, so software polls the bit it set
  wire [7:0] imageZero = switch_global_pkg::RESERVED_ONES
    | {2'b00, flushDynBusy, flushStatBusy, 2'b00, compliance_drop_mode, linkChangeAge};
  wire [7:0] readMux = selZero ? imageZero : (selOne ? ctrlOne : 8'h00);

  // Table walk decisions
  // Tables answer in the same cycle, so a match and its erase strobe coincide
  // Every index is visited even when nothing matches; flush time is fixed, not minimal
  wire dynLast = dynIdx == switch_global_pkg::DYN_ADDR_W'(switch_global_pkg::DYN_TABLE_DEPTH - 1);
  wire statLast =
    statIdx == switch_global_pkg::STAT_ADDR_W'(switch_global_pkg::STAT_TABLE_DEPTH - 1);
  wire dynMatch = dynEntry.valid && learnDisable[dynEntry.port]; // see RULE_02
  wire statMatch = statEntry.valid && !statEntry.multicast && single_port(statEntry.fwdPorts)
    && ((statEntry.fwdPorts & learnDisable) != '0); // see RULE_04
  wire inDyn = flushState == switch_global_pkg::FL_DYN;
  wire inStat = flushState == switch_global_pkg::FL_STAT;
  wire dynDone = inDyn && dynLast;
  wire statDone = inStat && statLast;

  assign dynAddr = dynIdx;
  assign statAddr = statIdx;
  assign dynInvalidate = inDyn && dynMatch;
  assign statInvalidate = inStat && statMatch;

  // Frame drop decision
  // Pass-all lifts only the error drops; control frames are still filtered
  // Type/length values of 1500 and up are types, so the length check skips them
  wire ctrlDrop = compliance_drop_mode
    ? (frameInfo.typeLen == switch_global_pkg::MAC_CTRL_TYPE
       || frameInfo.destAddr == switch_global_pkg::PAUSE_DEST_ADDR) // see RULE_06
    : frameInfo.isFlowCtrl; // see RULE_07
  wire lenMismatch = ctrlOne[switch_global_pkg::CO_LEN_CHECK]
    && frameInfo.typeLen < 16'(switch_global_pkg::LEN_FIELD_LIMIT)
    && frameInfo.typeLen[11:0] != frameInfo.payloadLen
    && frameInfo.typeLen[15:12] == 4'h0; // see RULE_15
  wire oversize = ctrlOne[switch_global_pkg::CO_HUGE_2K]
    ? frameInfo.frameLen > switch_global_pkg::HUGE_FRAME_MAX
    : frameInfo.overLegacyMax; // see RULE_11
  wire errDrop = !ctrlOne[switch_global_pkg::CO_PASS_ALL]
    && (frameInfo.badFrame || lenMismatch || oversize); // see RULE_10

  // Aging interval selection
  // Tick when the count reaches limit minus one, so the period equals the limit
  // With aging off the count freezes rather than clears; re-enabling resumes it
  wire [3:0] linkLost = linkPrev & ~linkUp;
  wire anyLinkLost = linkLost != 4'h0;
  wire useFast = ctrlOne[switch_global_pkg::CO_FAST_AGE] || fastPending; // see RULE_17
  wire [switch_global_pkg::AGE_CNT_W-1:0] ageLimit = useFast ? FAST_AGE_CYCLES : NORMAL_AGE_CYCLES;
  wire agingOn = ctrlOne[switch_global_pkg::CO_AGING_EN]; // see RULE_16
  wire ageExpire = agingOn && (ageCnt >= ageLimit - 1'b1);

  // Strap pins cross into clk through two flops
  // Straps are read once after reset; later pin changes wait for the next reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapMeta <= 2'b00;
      strapSync <= 2'b00;
    end else begin
      strapMeta <= {flow_ctrl_strap_pin, backoff_strap_pin};
      strapSync <= strapMeta;
    end
  end

  // Wait for the synchronisers to fill before the strap bits are loaded
  // The settle count gives the two-flop chain time to fill before its value is used
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strapWait <= 2'b00;
      strapDone <= 1'b0;
    end else if (!strapDone) begin
      strapWait <= strapWait + 2'b01;
      strapDone <= strapWait == switch_global_pkg::STRAP_SETTLE;
    end
  end

  // Global control zero: plain control bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compliance_drop_mode <= switch_global_pkg::RESET_CTRL_ZERO[switch_global_pkg::CZ_COMPLIANCE];
      linkChangeAge <= switch_global_pkg::RESET_CTRL_ZERO[switch_global_pkg::CZ_LINK_AGE];
    end else if (wrZero) begin
      compliance_drop_mode <= regWrData[switch_global_pkg::CZ_COMPLIANCE];
      linkChangeAge <= regWrData[switch_global_pkg::CZ_LINK_AGE];
    end
  end

  // Global control one; strap bits load once, later writes win
  // A write in the load cycle beats the strap; a write before that cycle has its strap bits overwritten
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlOne <= switch_global_pkg::RESET_CTRL_ONE;
    end else if (wrOne) begin
      ctrlOne <= regWrData;
    end else if (!strapDone && strapWait == switch_global_pkg::STRAP_SETTLE) begin
      ctrlOne[switch_global_pkg::CO_TX_FC_DIS] <= strapSync[1]; // see RULE_14
      ctrlOne[switch_global_pkg::CO_RX_FC_DIS] <= strapSync[1]; // see RULE_14
      ctrlOne[switch_global_pkg::CO_AGGR_BACKOFF] <= strapSync[0]; // see RULE_18
    end
  end

  // Flush trigger bits stay set until their walk ends; a new trigger wins
  // A trigger in the last walk cycle keeps the bit up, and the walker starts again
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flushDynBusy <= 1'b0;
      flushStatBusy <= 1'b0;
    end else begin
      flushDynBusy <= reqDyn || (flushDynBusy && !dynDone); // see RULE_01, RULE_19
      flushStatBusy <= reqStat || (flushStatBusy && !statDone); // see RULE_03, RULE_19
    end
  end

  // Flush walker: dynamic table first, then static, one entry per cycle
  // A static request waits for the dynamic walk, so both bits may read one a while
  always_comb begin
    case (flushState)
      switch_global_pkg::FL_IDLE: begin
        if (flushDynBusy) begin
          next_flushState = switch_global_pkg::FL_DYN;
        end else if (flushStatBusy) begin
          next_flushState = switch_global_pkg::FL_STAT;
        end else begin
          next_flushState = switch_global_pkg::FL_IDLE;
        end
      end
      switch_global_pkg::FL_DYN: begin
        if (!dynLast) begin
          next_flushState = switch_global_pkg::FL_DYN;
        end else if (flushStatBusy) begin
          next_flushState = switch_global_pkg::FL_STAT;
        end else begin
          next_flushState = switch_global_pkg::FL_IDLE;
        end
      end
      switch_global_pkg::FL_STAT: begin
        next_flushState = statLast ? switch_global_pkg::FL_IDLE : switch_global_pkg::FL_STAT;
      end
      default: begin
        next_flushState = switch_global_pkg::FL_IDLE;
      end
    endcase
  end

  // Walker state and indices
  // An index rests at zero whenever its walk is not running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flushState <= switch_global_pkg::FL_IDLE;
      dynIdx <= '0;
      statIdx <= '0;
    end else begin
      flushState <= next_flushState;
      dynIdx <= inDyn ? dynIdx + 1'b1 : '0;
      statIdx <= inStat ? statIdx + 1'b1 : '0;
    end
  end

  // Read answer one cycle after the strobe
  // Read data holds until the next read, so a late sampler still sees it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= readMux; // see RULE_05
      end
    end
  end

  // Frame verdict one cycle after the summary
  // The verdict holds between frames; only dropValid marks a fresh one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dropValid <= 1'b0;
      dropFrame <= 1'b0;
    end else begin
      dropValid <= frameValid;
      if (frameValid) begin
        dropFrame <= ctrlDrop || errDrop;
      end
    end
  end

  // Flow control gating and mode outputs
  // Registered for a clean one-cycle lag; a change of mode never glitches the outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txFlowEn <= 1'b0;
      rxFlowEn <= 1'b0;
      aggressiveBackoff <= 1'b0;
      hugeFrameEn <= 1'b0;
    end else begin
      txFlowEn <= anTxPause && !ctrlOne[switch_global_pkg::CO_TX_FC_DIS]; // see RULE_12
      rxFlowEn <= anRxPause && !ctrlOne[switch_global_pkg::CO_RX_FC_DIS]; // see RULE_13
      aggressiveBackoff <= ctrlOne[switch_global_pkg::CO_AGGR_BACKOFF]; // see RULE_18
      hugeFrameEn <= ctrlOne[switch_global_pkg::CO_HUGE_2K]; // see RULE_11
    end
  end

  // Aging timer; a link loss arms one fast cycle, then the normal period returns
  // Link loss restarts the count, so the fast cycle is a whole fast period
  // A loss and an expiry in one cycle: the loss wins and arms the fast cycle again
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ageCnt <= '0;
      fastPending <= 1'b0;
      linkPrev <= '0;
      ageTick <= 1'b0;
      ageAll <= 1'b0;
    end else begin
      linkPrev <= linkUp;
      ageTick <= ageExpire;
      ageAll <= anyLinkLost; // see RULE_09
      if (anyLinkLost && linkChangeAge) begin
        fastPending <= 1'b1; // see RULE_08
        ageCnt <= '0;
      end else if (ageExpire) begin
        fastPending <= 1'b0; // see RULE_08
        ageCnt <= '0;
      end else if (agingOn) begin
        ageCnt <= ageCnt + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* hdl/switch_global_pkg.sv */
// Constants, register layout and carrier types for the switch global control bits.
// Assumes one 25 MHz system clock shared by every user of this package.
package switch_global_pkg;

  // Register addresses on the management register port
  localparam logic [7:0] ADDR_GLOBAL_CTRL_ZERO = 8'h02;
  localparam logic [7:0] ADDR_GLOBAL_CTRL_ONE = 8'h03;

  // Field positions, global control zero
  localparam int CZ_FLUSH_DYN = 5;
  localparam int CZ_FLUSH_STAT = 4;
  localparam int CZ_RSVD_HI = 3;
  localparam int CZ_RSVD_LO = 2;
  localparam int CZ_COMPLIANCE = 1;
  localparam int CZ_LINK_AGE = 0;

  // Field positions, global control one
  localparam int CO_PASS_ALL = 7;
  localparam int CO_HUGE_2K = 6;
  localparam int CO_TX_FC_DIS = 5;
  localparam int CO_RX_FC_DIS = 4;
  localparam int CO_LEN_CHECK = 3;
  localparam int CO_AGING_EN = 2;
  localparam int CO_FAST_AGE = 1;
  localparam int CO_AGGR_BACKOFF = 0;

  // Reset values; strap-driven bits are loaded after release
  localparam logic [7:0] RESET_CTRL_ZERO = 8'h0c;
  localparam logic [7:0] RESET_CTRL_ONE = 8'h04;
  localparam logic [7:0] RESERVED_ONES = 8'h0c;

  // Frame classification constants
  localparam logic [15:0] MAC_CTRL_TYPE = 16'h8808;
  localparam logic [47:0] PAUSE_DEST_ADDR = 48'h0180c2000001;
  localparam logic [11:0] LEN_FIELD_LIMIT = 12'h5dc;
  localparam logic [11:0] HUGE_FRAME_MAX = 12'h800;

  // Table geometry
  localparam int NUM_PORTS = 4;
  localparam int DYN_TABLE_DEPTH = 1024;
  localparam int DYN_ADDR_W = 10;
  localparam int STAT_TABLE_DEPTH = 32;
  localparam int STAT_ADDR_W = 5;

  // Timing: printed figures and derived cycle counts
  localparam longint CLK_HZ = 64'd25000000;
  localparam longint FAST_AGE_US = 64'd800;
  localparam longint NORMAL_AGE_S = 64'd300;
  localparam int AGE_CNT_W = 34;
  localparam logic [AGE_CNT_W-1:0] FAST_AGE_CYCLES =
    AGE_CNT_W'((FAST_AGE_US * CLK_HZ) / 64'd1000000);
  localparam logic [AGE_CNT_W-1:0] NORMAL_AGE_CYCLES = AGE_CNT_W'(NORMAL_AGE_S * CLK_HZ);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Flush sequencer states
  typedef enum logic [2:0] {
    FL_IDLE = 3'b001,
    FL_DYN = 3'b010,
    FL_STAT = 3'b100
  } flush_state_t;

  // Dynamic table entry as seen by the flush walker
  typedef struct packed {
    logic valid;
    logic [1:0] port;
  } dyn_entry_t;

  // Static table entry as seen by the flush walker
  typedef struct packed {
    logic valid;
    logic multicast;
    logic [NUM_PORTS-1:0] fwdPorts;
  } stat_entry_t;

  // Per-frame summary handed in by the receive path
  typedef struct packed {
    logic [15:0] typeLen;
    logic [47:0] destAddr;
    logic isFlowCtrl;
    logic badFrame;
    logic overLegacyMax;
    logic [11:0] frameLen;
    logic [11:0] payloadLen;
  } frame_info_t;

endpackage

/* verification/switch_global_control_checker.sv */
// Port-level assertions for the switch global control bits.
// Assumes binding to switch_global_control with its fast age count passed on.
`timescale 1ns/1ps
`default_nettype none

module switch_global_control_checker #(
  parameter logic [switch_global_pkg::AGE_CNT_W-1:0] FAST_AGE_CYCLES = 34'h14
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic [3:0] learnDisable,
  input wire logic [3:0] linkUp,
  input wire logic [9:0] dynAddr,
  input wire switch_global_pkg::dyn_entry_t dynEntry,
  input wire logic dynInvalidate,
  input wire switch_global_pkg::stat_entry_t statEntry,
  input wire logic statInvalidate,
  input wire logic frameValid,
  input wire switch_global_pkg::frame_info_t frameInfo,
  input wire logic dropFrame,
  input wire logic anTxPause,
  input wire logic anRxPause,
  input wire logic txFlowEn,
  input wire logic rxFlowEn,
  input wire logic ageTick,
  input wire logic ageAll
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [3:0] linkPrev;
  logic [switch_global_pkg::AGE_CNT_W-1:0] sinceTick;
  wire logic linkDrop;
  assign linkDrop = |(linkPrev & ~linkUp);
  // Link history and age tick spacing; both restart with reset so no stale edge counts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      linkPrev <= '0;
      sinceTick <= '0;
    end else begin
      linkPrev <= linkUp;
      sinceTick <= ageTick ? '0 : sinceTick + 1'b1;
    end
  end
  property p_rsvd;
    $past(regRead) && $past(regAddr) == switch_global_pkg::ADDR_GLOBAL_CTRL_ZERO
      |-> regRdData[3:2] == 2'b11;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");
  property p_dyn;
    dynInvalidate |-> dynEntry.valid && learnDisable[dynEntry.port];
  endproperty
  a_dyn: assert property (p_dyn) else $error("bad dynamic erase");
  property p_stat;
    statInvalidate |-> statEntry.valid && !statEntry.multicast
      && $onehot(statEntry.fwdPorts) && |(statEntry.fwdPorts & learnDisable);
  endproperty
  a_stat: assert property (p_stat) else $error("bad static erase");
  property p_walk;
    dynAddr != 10'h000 && dynAddr != 10'h3ff |=> dynAddr == $past(dynAddr) + 10'h001;
  endproperty
  a_walk: assert property (p_walk) else $error("walk skipped an index");
  property p_tx;
    !$past(anTxPause) |-> !txFlowEn;
  endproperty
  a_tx: assert property (p_tx) else $error("tx flow without pause");
  property p_rx;
    !$past(anRxPause) |-> !rxFlowEn;
  endproperty
  a_rx: assert property (p_rx) else $error("rx flow without pause");
  property p_all;
    linkDrop |=> ageAll;
  endproperty
  a_all: assert property (p_all) else $error("no age-all on link loss");
  property p_period;
    ageTick |-> sinceTick >= FAST_AGE_CYCLES - 1'b1;
  endproperty
  a_period: assert property (p_period) else $error("age ticks too close");
  property p_ctrl;
    frameValid && frameInfo.isFlowCtrl && frameInfo.typeLen == 16'h8808 |=> dropFrame;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control frame kept");
  c_dyn: cover property (dynInvalidate);
  c_stat: cover property (statInvalidate);
  c_all: cover property (ageAll);
endmodule

bind switch_global_control switch_global_control_checker #(
  .FAST_AGE_CYCLES(FAST_AGE_CYCLES)
) i_checker (
  .clk(clk), .resetn(resetn), .regRead(regRead), .regAddr(regAddr), .regRdData(regRdData),
  .learnDisable(learnDisable), .linkUp(linkUp), .dynAddr(dynAddr), .dynEntry(dynEntry),
  .dynInvalidate(dynInvalidate), .statEntry(statEntry), .statInvalidate(statInvalidate),
  .frameValid(frameValid), .frameInfo(frameInfo), .dropFrame(dropFrame),
  .anTxPause(anTxPause), .anRxPause(anRxPause), .txFlowEn(txFlowEn), .rxFlowEn(rxFlowEn),
  .ageTick(ageTick), .ageAll(ageAll)
);
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the switch global control bits.
// Assumes short age counts (fast 20, normal 100) and table contents that follow the index.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [7:0] R0 = switch_global_pkg::ADDR_GLOBAL_CTRL_ZERO;
  localparam logic [7:0] R1 = switch_global_pkg::ADDR_GLOBAL_CTRL_ONE;
  logic clk, resetn, regWrite, regRead, flowStrap, backoffStrap, frameValid;
  logic anTxPause, anRxPause, regRdValid, dynInvalidate, statInvalidate, dropValid, dropFrame;
  logic txFlowEn, rxFlowEn, ageTick, ageAll, aggressiveBackoff, hugeFrameEn;
  logic [7:0] regAddr, regWrData, regRdData, d;
  logic [3:0] learnDisable, linkUp;
  logic [9:0] dynAddr;
  logic [4:0] statAddr;
  switch_global_pkg::dyn_entry_t dynEntry;
  switch_global_pkg::stat_entry_t statEntry;
  switch_global_pkg::frame_info_t frameInfo;
  int failures, checkCount, dynCount, statCount, tickCount, allCount, i;

  switch_global_control #(.FAST_AGE_CYCLES(34'h14), .NORMAL_AGE_CYCLES(34'h64)) i_dut (
    .clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .flow_ctrl_strap_pin(flowStrap), .backoff_strap_pin(backoffStrap),
    .learnDisable(learnDisable), .linkUp(linkUp), .dynAddr(dynAddr), .dynEntry(dynEntry),
    .dynInvalidate(dynInvalidate), .statAddr(statAddr), .statEntry(statEntry),
    .statInvalidate(statInvalidate), .frameValid(frameValid), .frameInfo(frameInfo),
    .dropValid(dropValid), .dropFrame(dropFrame), .anTxPause(anTxPause),
    .anRxPause(anRxPause), .txFlowEn(txFlowEn), .rxFlowEn(rxFlowEn), .ageTick(ageTick),
    .ageAll(ageAll), .aggressiveBackoff(aggressiveBackoff), .hugeFrameEn(hugeFrameEn));

  // Tables follow the index: ports 0 and 2 get 256 dynamic and two static matches per walk
  assign dynEntry = {dynAddr[2], dynAddr[1:0]};
  assign statEntry = {1'b1, statAddr[4], statAddr[3:0]};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Event tallies taken on the design's own edge
  always @(posedge clk) begin
    dynCount += int'(dynInvalidate === 1'b1);
    statCount += int'(statInvalidate === 1'b1);
    tickCount += int'(ageTick === 1'b1);
    allCount += int'(ageAll === 1'b1);
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (failures == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge clk);
    regWrite = 1'b0;
  endtask

  // Data is taken at the negedge inside the one-cycle valid pulse
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
  endtask

  task automatic frm(input logic [15:0] tl, input logic [47:0] da, input logic [2:0] fl,
                     input logic [11:0] len, input logic [11:0] pay, input logic exp);
    @(negedge clk);
    frameValid = 1'b1;
    frameInfo = {tl, da, fl, len, pay};
    @(negedge clk);
    frameValid = 1'b0;
    chk("drop verdict", {14'h0, dropValid, dropFrame}, {14'h0, 1'b1, exp});
  endtask

  initial begin
    {resetn, regWrite, regRead, frameValid, failures, checkCount} = '0;
    {dynCount, statCount, tickCount, allCount, regAddr, regWrData, frameInfo} = '0;
    {flowStrap, backoffStrap, anTxPause, anRxPause, learnDisable, linkUp} = 12'hf5f;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (7) @(negedge clk);
    rd(R1);
    chk("control one", d, 8'h35);
    chk("flow enables", {txFlowEn, rxFlowEn}, 2'b00);
    chk("back-off", aggressiveBackoff, 1'b1);
    rd(R0);
    chk("control zero", d, 8'h0c);
    rd(8'h07);
    chk("unmapped", d, 8'h00);
    wr(R0, 8'hc3);
    rd(R0);
    chk("control zero", d, 8'h0f);
    frm(16'h8808, 48'h0, 3'b000, 12'h40, 12'h2e, 1'b1);
    frm(16'h0800, switch_global_pkg::PAUSE_DEST_ADDR, 3'b000, 12'h40, 12'h2e, 1'b1);
    frm(16'h8808, switch_global_pkg::PAUSE_DEST_ADDR, 3'b100, 12'h40, 12'h2e, 1'b1);
    frm(16'h0800, 48'h0, 3'b100, 12'h40, 12'h2e, 1'b0);
    wr(R0, 8'h0c);
    frm(16'h0800, 48'h0, 3'b100, 12'h40, 12'h2e, 1'b1);
    frm(16'h8808, 48'h0, 3'b000, 12'h40, 12'h2e, 1'b0);
    wr(R1, 8'h3d);
    frm(16'h0064, 48'h0, 3'b000, 12'h64, 12'h32, 1'b1);
    frm(16'h0064, 48'h0, 3'b000, 12'h64, 12'h64, 1'b0);
    frm(16'h05dc, 48'h0, 3'b000, 12'h64, 12'h32, 1'b0);
    frm(16'h0800, 48'h0, 3'b010, 12'h40, 12'h2e, 1'b1);
    wr(R1, 8'hbd);
    frm(16'h0800, 48'h0, 3'b010, 12'h40, 12'h2e, 1'b0);
    frm(16'h0064, 48'h0, 3'b000, 12'h64, 12'h32, 1'b0);
    wr(R1, 8'h35);
    frm(16'h0800, 48'h0, 3'b001, 12'h7d0, 12'h2e, 1'b1);
    wr(R1, 8'h75);
    frm(16'h0800, 48'h0, 3'b001, 12'h7d0, 12'h2e, 1'b0);
    frm(16'h0800, 48'h0, 3'b000, 12'h801, 12'h2e, 1'b1);
    wr(R1, 8'h64);
    @(negedge clk);
    chk("flow enables", {txFlowEn, rxFlowEn, hugeFrameEn}, 3'b011);
    chk("back-off", aggressiveBackoff, 1'b0);
    wr(R1, 8'h14);
    anRxPause = 1'b0;
    @(negedge clk);
    chk("flow enables", {txFlowEn, rxFlowEn}, 2'b10);
    wr(R0, 8'h30);
    rd(R0);
    chk("busy bits", d, 8'h3c);
    for (i = 0; i < 800 && d[5:4] !== 2'b00; i++) rd(R0);
    chk("flush done", d, 8'h0c);
    if (i == 800) end_sim();
    chk("dynamic erased", dynCount, 256);
    chk("static erased", statCount, 2);
    wr(R1, 8'h06);
    for (i = 0; i < 40 && ageTick !== 1'b1; i++) @(negedge clk);
    chk("tick wait", 16'(i == 40), 16'h0000);
    if (i == 40) end_sim();
    tickCount = 0;
    repeat (190) @(negedge clk);
    chk("fast ticks", tickCount, 10);
    wr(R1, 8'h02);
    tickCount = 0;
    repeat (100) @(negedge clk);
    chk("ticks while off", tickCount, 0);
    wr(R1, 8'h04);
    wr(R0, 8'h0d);
    @(negedge clk);
    {tickCount, allCount} = '0;
    linkUp = 4'hd;
    repeat (60) @(negedge clk);
    chk("link loss ticks", tickCount, 1);
    chk("age all", allCount, 1);
    // Second reset with both straps low: flow control on, back-off off
    resetn = 1'b0;
    {flowStrap, backoffStrap, anRxPause} = 3'h1;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (7) @(negedge clk);
    rd(R1);
    chk("control one", d, 8'h04);
    chk("modes", {txFlowEn, rxFlowEn, aggressiveBackoff}, 3'h6);
    rd(R0);
    chk("control zero", d, 8'h0c);
    end_sim();
  end
endmodule
`default_nettype wire
